// [inc/fpe_pkg.sv]
// Package for the flash program/erase host controller.
// Assumes a 100 MHz clock and an asynchronous parallel flash on the pins.
package fpe_pkg;
	localparam int CLK_PERIOD_NS = 10;
	// Pin timing figures in ns (least times, rounded up to cycles)
	localparam int T_WC_NS  = 70;
	localparam int T_WP_NS  = 35;
	localparam int T_WPH_NS = 20;
	localparam int T_ACC_NS = 70;
	localparam int T_OEH_NS = 20;
	localparam int WC_CYC   = (T_WC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WP_CYC   = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WPH_CYC  = (T_WPH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ACC_CYC  = (T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int OEH_CYC  = (T_OEH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W    = 4;

	localparam int ADDR_W = 23;
	localparam int DATA_W = 16;

	// Status bit positions on the data lines
	localparam int POLL_BIT   = 7;
	localparam int TOGGLE_BIT = 6;
	localparam int ETOG_BIT   = 2;

	// Command cycle values
	localparam logic [ADDR_W-1:0] UNLOCK_ADDR1 = 23'h000555;
	localparam logic [ADDR_W-1:0] UNLOCK_ADDR2 = 23'h0002aa;
	localparam logic [DATA_W-1:0] UNLOCK_DATA1 = 16'h00aa;
	localparam logic [DATA_W-1:0] UNLOCK_DATA2 = 16'h0055;
	localparam logic [DATA_W-1:0] ERASE_SETUP  = 16'h0080;
	localparam logic [DATA_W-1:0] PROG_SETUP   = 16'h00a0;
	localparam logic [DATA_W-1:0] CHIP_ERASE   = 16'h0010;
	localparam logic [DATA_W-1:0] BLOCK_ERASE  = 16'h0030;
	localparam logic [ADDR_W-1:0] CHIP_ADDR    = 23'h000555;

	typedef enum logic [1:0] {
		FPE_OP_PROGRAM = 2'h0,
		FPE_OP_BLOCK   = 2'h1,
		FPE_OP_CHIP    = 2'h2
	} fpe_op_e;

	typedef struct packed {
		fpe_op_e             op;
		logic [ADDR_W-1:0]   program_location_address;
		logic [DATA_W-1:0]   program_value;
	} fpe_req_s;

	typedef struct packed {
		logic                ce_n;
		logic                we_n;
		logic                oe_n;
		logic [ADDR_W-1:0]   addr;
		logic [DATA_W-1:0]   dq_o;
		logic                dq_oe;
	} fpe_bus_s;
endpackage : fpe_pkg

// [hdl/fpe_sync.sv]
// Two-flop synchroniser for a bundle of pin inputs.
// Assumes inputs asynchronous to clk; output lags by two edges.
`timescale 1ns/1ns
module fpe_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         reset_n,
	// Data
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_q;

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			meta_q <= '0;
			q      <= '0;
		end else begin
			meta_q <= d;
			q      <= meta_q;
		end
	end
endmodule : fpe_sync

// [hdl/fpe_host.sv]
// Host controller: issues program, block erase and chip erase to a parallel
// flash through its pins, then polls status until done and, after a program only, reads back.
// Assumes dq is resolved outside from dq_o/dq_oe; ready_busy_n is only watched.
`timescale 1ns/1ns

// Function
// - A chip erase ends with data 10h written to address 555h.
// - A block erase ends with data 30h written to an address inside the block.
// - A program command carries the target location on address and the value on data.
// - After a program the host polls the polling bit until done, then reads the location.
module fpe_host #(
	parameter int POLL_LIMIT = 65535
) (
	// Clock and reset
	input  wire logic                         clk,
	input  wire logic                         reset_n,
	// User request
	input  wire logic                         req_valid,
	input  wire fpe_pkg::fpe_req_s            req,
	output logic                              req_ready,
	output logic                              done,
	output logic                              fail,
	output logic [fpe_pkg::DATA_W-1:0]        read_value,
	// Flash pins
	output logic                              ce_n,
	output logic                              we_n,
	output logic                              oe_n,
	output logic [fpe_pkg::ADDR_W-1:0]        addr,
	output logic [fpe_pkg::DATA_W-1:0]        dq_o,
	output logic                              dq_oe,
	input  wire logic [fpe_pkg::DATA_W-1:0]   dq_i,
	input  wire logic                         ready_busy_n
);
	typedef enum logic [2:0] {
		ST_IDLE  = 3'h0,
		ST_WLOW  = 3'h1,
		ST_WHIGH = 3'h2,
		ST_RLOW  = 3'h3,
		ST_RHIGH = 3'h4,
		ST_FINAL = 3'h5
	} fpe_state_e;

	fpe_state_e                    state_q, state_d;
	fpe_pkg::fpe_req_s             req_q;
	fpe_pkg::fpe_bus_s             bus_q, bus_d;
	logic [2:0]                    cyc_q, cyc_d;
	logic [fpe_pkg::CNT_W-1:0]     cnt_q, cnt_d;
	logic [31:0]                   polls_q, polls_d;
	logic                          have_prev_q, have_prev_d;
	logic [fpe_pkg::DATA_W-1:0]    prev_q, prev_d;
	logic [fpe_pkg::DATA_W-1:0]    value_q, value_d;
	logic                          done_q, done_d, fail_q, fail_d, rdy_q, rdy_d;
	logic [fpe_pkg::DATA_W-1:0]    dq_s;
	logic                          rb_s;

	fpe_sync #(.W(fpe_pkg::DATA_W + 1)) u_sync (
		.clk     (clk),
		.reset_n (reset_n),
		.d       ({ready_busy_n, dq_i}),
		.q       ({rb_s, dq_s})
	);

	// Command cycle table: index 0..3 for program, 0..5 for erase, last cycle is the final one
	logic [fpe_pkg::ADDR_W-1:0] cmd_addr;
	logic [fpe_pkg::DATA_W-1:0] cmd_data;
	logic [2:0]                 last_cyc;
	wire                        is_prog = (req_q.op == fpe_pkg::FPE_OP_PROGRAM);
	assign last_cyc = is_prog ? 3'h3 : 3'h5;

	always_comb begin
		cmd_addr = fpe_pkg::UNLOCK_ADDR1;
		cmd_data = fpe_pkg::UNLOCK_DATA1;
		case (cyc_q)
			3'h1, 3'h4: begin
				cmd_addr = fpe_pkg::UNLOCK_ADDR2;
				cmd_data = fpe_pkg::UNLOCK_DATA2;
			end
			3'h2: cmd_data = is_prog ? fpe_pkg::PROG_SETUP : fpe_pkg::ERASE_SETUP;
			3'h3: begin
				if (is_prog) begin
					cmd_addr = req_q.program_location_address;
					cmd_data = req_q.program_value;
				end
			end
			3'h5: begin
				if (req_q.op == fpe_pkg::FPE_OP_CHIP) begin
					cmd_addr = fpe_pkg::CHIP_ADDR;
					cmd_data = fpe_pkg::CHIP_ERASE;
				end else begin
					cmd_addr = req_q.program_location_address;
					cmd_data = fpe_pkg::BLOCK_ERASE;
				end
			end
			default: ;
		endcase
	end

	// Completion tests on a polled status word
	wire poll_true = (dq_s[fpe_pkg::POLL_BIT] == req_q.program_value[fpe_pkg::POLL_BIT]);
	wire tog_same  = (dq_s[fpe_pkg::TOGGLE_BIT] == prev_q[fpe_pkg::TOGGLE_BIT]);
	wire etog_same = (dq_s[fpe_pkg::ETOG_BIT] == prev_q[fpe_pkg::ETOG_BIT]);
	// Erase: both toggle bits steady across two reads means finished
	wire erase_done = have_prev_q && tog_same && etog_same;
	wire prog_done  = poll_true;
	wire op_done    = is_prog ? prog_done : erase_done;
	wire timeout    = (polls_q >= POLL_LIMIT);
	// Readback low phase needs full access time plus the synchroniser lag
	wire [fpe_pkg::CNT_W-1:0] final_lim = bus_q.ce_n ? fpe_pkg::CNT_W'(fpe_pkg::WC_CYC)
	                                                 : fpe_pkg::CNT_W'(fpe_pkg::ACC_CYC + 2);

	always_comb begin
		state_d     = state_q;
		bus_d       = bus_q;
		cyc_d       = cyc_q;
		cnt_d       = cnt_q;
		polls_d     = polls_q;
		have_prev_d = have_prev_q;
		prev_d      = prev_q;
		value_d     = value_q;
		done_d      = 1'b0;
		fail_d      = 1'b0;
		rdy_d       = rdy_q;
		case (state_q)
			ST_IDLE: begin
				if (req_valid && rdy_q) begin
					rdy_d       = 1'b0;
					cyc_d       = 3'h0;
					polls_d     = '0;
					have_prev_d = 1'b0;
					state_d     = ST_WHIGH;
					cnt_d       = '0;
				end
			end
			ST_WHIGH: begin
				// Strobes high, address stable before the fall
				bus_d.ce_n  = 1'b1;
				bus_d.we_n  = 1'b1;
				bus_d.oe_n  = 1'b1;
				bus_d.dq_oe = 1'b0;
				// Address and data settle before the strobes fall, no race on the pins
				bus_d.addr  = cmd_addr;
				bus_d.dq_o  = cmd_data;
				cnt_d = cnt_q + 1'b1;
				if (cnt_q >= fpe_pkg::CNT_W'(fpe_pkg::WPH_CYC)) begin
					bus_d.dq_oe = 1'b1;
					bus_d.ce_n  = 1'b0;
					bus_d.we_n  = 1'b0;
					cnt_d   = '0;
					state_d = ST_WLOW;
				end
			end
			ST_WLOW: begin
				cnt_d = cnt_q + 1'b1;
				// Data held through both strobes rising together
				if (cnt_q >= fpe_pkg::CNT_W'(fpe_pkg::WP_CYC)) begin
					bus_d.we_n = 1'b1;
					bus_d.ce_n = 1'b1;
					cnt_d      = '0;
					if (cyc_q == last_cyc)
						state_d = ST_RHIGH;
					else begin
						cyc_d   = cyc_q + 3'h1;
						state_d = ST_WHIGH;
					end
				end
			end
			ST_RHIGH: begin
				// Read recovery between polls, also covers the busy flag delay
				bus_d.dq_oe = 1'b0;
				bus_d.oe_n  = 1'b1;
				bus_d.ce_n  = 1'b1;
				bus_d.addr  = req_q.program_location_address;
				cnt_d = cnt_q + 1'b1;
				if (cnt_q >= fpe_pkg::CNT_W'(fpe_pkg::OEH_CYC)) begin
					bus_d.ce_n = 1'b0;
					bus_d.oe_n = 1'b0;
					cnt_d   = '0;
					state_d = ST_RLOW;
				end
			end
			ST_RLOW: begin
				cnt_d = cnt_q + 1'b1;
				// Two extra cycles cover the input synchroniser
				if (cnt_q >= fpe_pkg::CNT_W'(fpe_pkg::ACC_CYC + 2)) begin
					bus_d.oe_n  = 1'b1;
					bus_d.ce_n  = 1'b1;
					cnt_d       = '0;
					prev_d      = dq_s;
					have_prev_d = 1'b1;
					polls_d     = polls_q + 32'h1;
					if (op_done) begin
						// Program goes on to a final read of the stored word; erase finishes here
						state_d = is_prog ? ST_FINAL : ST_IDLE;
						value_d = dq_s;
						if (!is_prog) begin
							done_d = 1'b1;
							rdy_d  = 1'b1;
						end
					end else if (timeout) begin
						fail_d  = 1'b1;
						rdy_d   = 1'b1;
						state_d = ST_IDLE;
					end else
						state_d = ST_RHIGH;
				end
			end
			ST_FINAL: begin
				// One more full read gives the stored value once polling settles
				bus_d.oe_n = 1'b1;
				cnt_d = cnt_q + 1'b1;
				if (cnt_q >= final_lim) begin
					cnt_d = '0;
					if (bus_q.ce_n) begin
						bus_d.ce_n = 1'b0;
						bus_d.oe_n = 1'b0;
					end else begin
						bus_d.ce_n = 1'b1;
						value_d    = dq_s;
						done_d     = 1'b1;
						rdy_d      = 1'b1;
						state_d    = ST_IDLE;
					end
				end else if (!bus_q.ce_n)
					bus_d.oe_n = 1'b0;
			end
			default: state_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			state_q     <= ST_IDLE;
			bus_q       <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, addr: '0, dq_o: '0, dq_oe: 1'b0};
			cyc_q       <= '0;
			cnt_q       <= '0;
			polls_q     <= '0;
			have_prev_q <= 1'b0;
			prev_q      <= '0;
			value_q     <= '0;
			done_q      <= 1'b0;
			fail_q      <= 1'b0;
			rdy_q       <= 1'b1;
			req_q       <= '0;
		end else begin
			state_q     <= state_d;
			bus_q       <= bus_d;
			cyc_q       <= cyc_d;
			cnt_q       <= cnt_d;
			polls_q     <= polls_d;
			have_prev_q <= have_prev_d;
			prev_q      <= prev_d;
			value_q     <= value_d;
			done_q      <= done_d;
			fail_q      <= fail_d;
			rdy_q       <= rdy_d;
			if (state_q == ST_IDLE && req_valid && rdy_q)
				req_q <= req;
		end
	end

	assign req_ready  = rdy_q;
	assign done       = done_q;
	assign fail       = fail_q;
	assign read_value = value_q;
	assign ce_n       = bus_q.ce_n;
	assign we_n       = bus_q.we_n;
	assign oe_n       = bus_q.oe_n;
	assign addr       = bus_q.addr;
	assign dq_o       = bus_q.dq_o;
	assign dq_oe      = bus_q.dq_oe;

	// Busy pin is synchronised but only advisory; polling decides completion
	wire unused_rb = rb_s;
endmodule : fpe_host

// [tb/fpe_host_sva.sv]
// Checker for fpe_host: final command cycles and program readback.
// Assumes it is bound to fpe_host and sees only its ports.
`timescale 1ns/1ns
module fpe_host_sva (
	input wire logic              clk,
	input wire logic              reset_n,
	input wire logic              req_valid,
	input wire fpe_pkg::fpe_req_s req,
	input wire logic              req_ready,
	input wire logic              done,
	input wire logic              fail,
	input wire logic [15:0]       read_value,
	input wire logic              ce_n,
	input wire logic              we_n,
	input wire logic              oe_n,
	input wire logic [22:0]       addr,
	input wire logic [15:0]       dq_o,
	input wire logic              dq_oe,
	input wire logic [15:0]       dq_i,
	input wire logic              ready_busy_n
);
	fpe_pkg::fpe_req_s req_q;
	always_ff @(posedge clk) begin
		if (!reset_n)
			req_q <= '0;
		else if (req_valid && req_ready)
			req_q <= req;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	sequence s_setup;
		$fell(we_n) && !ce_n && req_q.op == fpe_pkg::FPE_OP_PROGRAM && dq_o == 16'h00a0;
	endsequence
	sequence s_data;
		##[1:20] ($fell(we_n) && dq_oe && addr == req_q.program_location_address && dq_o == req_q.program_value);
	endsequence
	property p_prog;
		s_setup |-> s_data;
	endproperty
	a_prog: assert property (p_prog) else $error("program data cycle wrong");
	property p_chip;
		$fell(we_n) && req_q.op == fpe_pkg::FPE_OP_CHIP && dq_o == 16'h0010 |-> addr == 23'h000555 && dq_oe;
	endproperty
	a_chip: assert property (p_chip) else $error("chip erase address wrong");
	property p_block;
		$fell(we_n) && req_q.op == fpe_pkg::FPE_OP_BLOCK && dq_o == 16'h0030 |-> addr == req_q.program_location_address;
	endproperty
	a_block: assert property (p_block) else $error("block erase address wrong");
	property p_block_code;
		$fell(we_n) && req_q.op == fpe_pkg::FPE_OP_BLOCK |-> dq_o != 16'h0010;
	endproperty
	a_block_code: assert property (p_block_code) else $error("block erase sent chip code");
	property p_readback;
		done && req_q.op == fpe_pkg::FPE_OP_PROGRAM |-> read_value == req_q.program_value;
	endproperty
	a_readback: assert property (p_readback) else $error("readback wrong");
	property p_done_ready;
		done || fail |-> req_ready && ce_n && oe_n && we_n && !dq_oe;
	endproperty
	a_done_ready: assert property (p_done_ready) else $error("finished while bus still held");
endmodule : fpe_host_sva

bind fpe_host fpe_host_sva fpe_host_sva_inst (
	.clk(clk), .reset_n(reset_n), .req_valid(req_valid), .req(req), .req_ready(req_ready),
	.done(done), .fail(fail), .read_value(read_value), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n),
	.addr(addr), .dq_o(dq_o), .dq_oe(dq_oe), .dq_i(dq_i), .ready_busy_n(ready_busy_n)
);

// [tb/fpe_flash_model.sv]
// Behavioural flash: command decode, embedded program/erase, status bits.
// Assumes the bench resolves dq; busy_reads sets status reads per operation.
`timescale 1ns/1ns
module fpe_flash_model (
	// Pins
	input wire logic        ce_n,
	input wire logic        we_n,
	input wire logic        oe_n,
	input wire logic [22:0] addr,
	input wire logic [15:0] din,
	output logic     [15:0] dout,
	output logic            ready_busy_n,
	// Bench control
	input wire logic [15:0] busy_reads
);
	wire         wr = ce_n | we_n;
	wire         rd = ce_n | oe_n;
	logic [15:0] mem [logic [22:0]];
	logic [22:0] a_cap;
	logic [15:0] pd;
	logic [15:0] left = 16'h0000;
	logic        pend_p = 1'b0, pend_e = 1'b0, erase = 1'b0, tog = 1'b0;
	initial dout = 16'h0000;
	assign ready_busy_n = left == 16'h0000;
	always @(negedge wr) a_cap = addr;
	always @(posedge wr) begin
		if (pend_p || (pend_e && (din == 16'h0010 || din == 16'h0030))) begin
			erase = !pend_p;
			// Any erase clears every block: simpler, never kinder
			if (erase)
				mem.delete();
			else
				mem[a_cap] = din;
			pd = din;
			left = busy_reads;
			pend_p = 1'b0;
			pend_e = 1'b0;
		end else begin
			pend_p = din == 16'h00a0;
			pend_e = pend_e || din == 16'h0080;
		end
	end
	always @(negedge rd) begin
		if (left != 16'h0000) begin
			tog = !tog;
			dout = ~dout;
			dout[7] = !erase && !pd[7];
			dout[6] = tog;
			dout[2] = erase && tog;
			left = left - 16'h0001;
		end else
			dout = mem.exists(addr) ? mem[addr] : 16'hffff;
	end
	// Released bus must not keep showing the last word
	always @(posedge rd) dout = ~dout;
endmodule : fpe_flash_model

// [tb/tb.sv]
// Bench for fpe_host: program, block and chip erase, prompt and slow device.
// Assumes the flash model on the pins; the bench resolves the data bus.
`timescale 1ns/1ns
module tb;
	logic              clk, reset_n, req_valid;
	fpe_pkg::fpe_req_s req;
	logic              req_ready, done, fail, ce_n, we_n, oe_n, dq_oe, ready_busy_n, got_done, got_fail;
	logic [22:0]       addr, last_a;
	logic [15:0]       read_value, dq_o, dev_dq, last_d, busy_reads;
	int                errors, tests_run, n_wr;
	wire logic [15:0]  dq_i = dq_oe ? dq_o : dev_dq;
	wire               wr_w = ce_n | we_n;

	fpe_host #(.POLL_LIMIT(50)) fpe_host_inst (
		.clk(clk), .reset_n(reset_n), .req_valid(req_valid), .req(req), .req_ready(req_ready),
		.done(done), .fail(fail), .read_value(read_value), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n),
		.addr(addr), .dq_o(dq_o), .dq_oe(dq_oe), .dq_i(dq_i), .ready_busy_n(ready_busy_n)
	);
	fpe_flash_model fpe_flash_model_inst (
		.ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .addr(addr), .din(dq_i), .dout(dev_dq),
		.ready_busy_n(ready_busy_n), .busy_reads(busy_reads)
	);
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge wr_w) begin
		n_wr++;
		last_a = addr;
		last_d = dq_o;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic summarize();
		$display("errors=%0d tests_run=%0d", errors, tests_run);
		if (errors == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : summarize
	task automatic issue(input fpe_pkg::fpe_op_e op, input logic [22:0] a, input logic [15:0] v, input logic [15:0] n);
		int i;
		busy_reads = n;
		n_wr = 0;
		@(posedge clk);
		req_valid <= 1'b1;
		req <= '{op, a, v};
		@(posedge clk);
		req_valid <= 1'b0;
		for (i = 0; i < 3000 && done !== 1'b1 && fail !== 1'b1; i++)
			@(negedge clk);
		if (i == 3000) begin
			errors++;
			summarize();
		end
		got_done = done;
		got_fail = fail;
	endtask : issue
	task automatic t_prog_slow();
		issue(fpe_pkg::FPE_OP_PROGRAM, 23'h012345, 16'h8a5c, 16'h0006);
		chk(got_done, 1);
		chk(read_value, 16'h8a5c);
		chk(n_wr, 4);
		chk(last_a, 23'h012345);
		chk(last_d, 16'h8a5c);
	endtask : t_prog_slow
	task automatic t_prog_prompt();
		issue(fpe_pkg::FPE_OP_PROGRAM, 23'h7fffff, 16'h0001, 16'h0000);
		chk(got_done, 1);
		chk(read_value, 16'h0001);
		chk(n_wr, 4);
		chk(last_a, 23'h7fffff);
		chk(last_d, 16'h0001);
	endtask : t_prog_prompt
	task automatic t_block_erase();
		issue(fpe_pkg::FPE_OP_BLOCK, 23'h3a0000, 16'h0000, 16'h0005);
		chk(got_done, 1);
		chk(n_wr, 6);
		chk(last_a, 23'h3a0000);
		chk(last_d, 16'h0030);
		chk(read_value, 16'hffff);
	endtask : t_block_erase
	task automatic t_chip_erase();
		issue(fpe_pkg::FPE_OP_CHIP, 23'h000000, 16'h0000, 16'h0001);
		chk(got_done, 1);
		chk(n_wr, 6);
		chk(last_a, 23'h000555);
		chk(last_d, 16'h0010);
		issue(fpe_pkg::FPE_OP_PROGRAM, 23'h7fffff, 16'h4000, 16'h0002);
		chk(read_value, 16'h4000);
	endtask : t_chip_erase
	// Device stays busy for 65535 status reads, far past POLL_LIMIT of 50: the host must give up
	task automatic t_poll_limit();
		issue(fpe_pkg::FPE_OP_PROGRAM, 23'h000100, 16'h00ff, 16'hffff);
		chk(got_fail, 1);
		chk(got_done, 0);
	endtask : t_poll_limit
	initial begin
		reset_n = 1'b0;
		req_valid = 1'b0;
		req = '0;
		busy_reads = 16'h0000;
		errors = 0;
		tests_run = 0;
		repeat (6) @(posedge clk);
		reset_n <= 1'b1;
		t_prog_slow();
		t_prog_prompt();
		t_block_erase();
		t_chip_erase();
		t_poll_limit();
		summarize();
	end
endmodule : tb
